/* File: pmc_pkg.sv */
package pmc_pkg;

  // Command register space
  localparam int unsigned NUM_CMD = 22;
  localparam logic [7:0] SUB_FIRST = 8'h01;
  localparam logic [7:0] SUB_LAST = 8'h16;
  localparam logic [7:0] CMD_RESET = 8'h00;

  // Fixed bus addresses, write has bit 0 clear, read has it set
  localparam logic [7:0] ADDR_WR_BASE = 8'h78;
  localparam logic [7:0] ADDR_RD_BASE = 8'h79;
  localparam logic [7:0] ADDR_WR_DDR = 8'h7a;
  localparam logic [7:0] ADDR_RD_DDR = 8'h7b;

  // Documented register offsets
  localparam logic [7:0] OFS_SWITCHER_ONE_CONTROL = 8'h01;
  localparam logic [7:0] OFS_SWITCHER_TWO_CONTROL = 8'h02;
  localparam logic [7:0] OFS_SWITCHER_THREE_CONTROL = 8'h03;
  localparam logic [7:0] OFS_SWITCHER_FOUR_CONTROL = 8'h04;
  localparam logic [7:0] OFS_LINEAR_REG_PAIR_CONTROL = 8'h05;
  localparam logic [7:0] OFS_LINEAR_REG_FOUR_CONTROL = 8'h06;
  localparam logic [7:0] OFS_POWERDOWN_ORDER_FIRST = 8'h07;

  // Switcher control fields
  localparam int unsigned SW_EN_BIT = 7;
  localparam int unsigned SW_MODE_LSB = 5;
  localparam int unsigned SW_STARTUP_BIT = 4;
  localparam int unsigned SW_PHASE_BIT = 3;
  localparam int unsigned SW_RATE_BIT = 2;
  localparam int unsigned SW_ALIVE_BIT = 1;
  localparam int unsigned SW_EDGE_BIT = 0;
  localparam logic [7:0] SW_MASK = 8'hff;

  // Linear regulator fields
  localparam int unsigned LIN3_EN_BIT = 5;
  localparam int unsigned LIN2_EN_BIT = 2;
  localparam int unsigned LIN4_EN_BIT = 2;
  localparam int unsigned LIN4_VSEL_LSB = 3;
  localparam logic [7:0] LIN_PAIR_MASK = 8'h3f;
  localparam logic [7:0] LIN_FOUR_MASK_BASE = 8'h07;
  localparam logic [7:0] LIN_FOUR_MASK_DDR = 8'h1f;

  // Power-down order: four 2-bit delay fields, 100 ms per step
  localparam int unsigned PD_FIELD_W = 2;
  localparam int unsigned PD_STEP_MS = 100;
  localparam logic [7:0] PD_MASK = 8'hff;
  localparam logic [7:0] GEN_MASK = 8'hff;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Idle bus level held in the sync stages while in reset
  localparam logic BUS_IDLE = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_WR_BYTE,
    ST_RD_BYTE,
    ST_RD_ACK
  } pmc_phase_e;

  typedef struct packed {
    logic scl;
    logic sda;
    logic [6:0] en_pin;
  } pmc_pins_s;

  typedef struct packed {
    pmc_pins_s sync1;
    pmc_pins_s sync2;
    logic scl_prev;
    logic sda_prev;
    pmc_phase_e phase;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic expect_sub;
    logic rd_mode;
    logic pending;
    logic [NUM_CMD-1:0][7:0] staged;
    logic [NUM_CMD-1:0][7:0] applied;
    logic sda_oe;
    logic sda_out;
    logic [6:0] rail_en;
  } pmc_state_s;

endpackage

/* File: pmc_i2c_command_port.sv */
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Address bit 0 selects direction: 0 write, 1 read.
// - Answer only the fixed address pair of the selected variant.
// - Twenty-two writable command registers, selected by sub-address.
// - Sub-address byte is a pointer; following data lands there.
// - Any number of sub-address/data pairs after one write address.
// - Written values reach the controls only at STOP.
// - Repeated START keeps writes; next STOP applies them all.
// - Read: write address, sub-address, new START, read address.
// - After read address ack, drive eight data bits; master acks ninth.
// - Keep last sub-address so reads can repeat without resending it.
// - Bare read returns the register at the last sub-address sent.
// - Switcher bit 7 enables, else pin; bits 6:5 select mode.
// - Switcher bit 4 selects start-up only below 300mV.
// - Switcher bit 3 selects clock phase, bit 2 switching rate.
// - Switcher bit 1 keeps alive in shutdown, bit 0 edge rate.
// - Pair register: LDO3 controls in bits 5:3, LDO2 in 2:0.
// - LDO4 controls in bits 2:0; DDR variant adds voltage bits 4:3.
// - Power-down register: four 2-bit delay fields, 100 ms steps.
// - Bytes are eight bits, MSB first, then one ack clock.
// - Ack write address and all write bytes; ack only read address.
// - Missing master ack after read data changes nothing.
module pmc_i2c_command_port
  import pmc_pkg::*;
#(
  parameter bit DDR_VARIANT = 1'b0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Serial bus, open drain data
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Rail enable pins
  input wire logic switcher_one_enable_pin,
  input wire logic switcher_two_enable_pin,
  input wire logic switcher_three_enable_pin,
  input wire logic switcher_four_enable_pin,
  input wire logic linear_two_enable_pin,
  input wire logic linear_three_enable_pin,
  input wire logic linear_four_enable_pin,
  // Applied command registers and resulting rail enables
  output logic [NUM_CMD-1:0][7:0] cmd_applied,
  output logic [6:0] rail_enable
);

  localparam logic [7:0] ADDR_WR = DDR_VARIANT ? ADDR_WR_DDR : ADDR_WR_BASE;
  localparam logic [7:0] ADDR_RD = DDR_VARIANT ? ADDR_RD_DDR : ADDR_RD_BASE;

  pmc_state_s st_reg;
  pmc_state_s st_next;

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic ptr_hit;
  logic [4:0] ptr_idx;
  logic [7:0] rd_byte;

  // Writable bits per sub-address; reserved bits are cleared on entry
  function automatic logic [7:0] wr_mask(input logic [7:0] sub);
    logic [7:0] m;
    m = GEN_MASK;
    if (sub == OFS_SWITCHER_ONE_CONTROL || sub == OFS_SWITCHER_TWO_CONTROL ||
        sub == OFS_SWITCHER_THREE_CONTROL ||
        sub == OFS_SWITCHER_FOUR_CONTROL) begin
      m = SW_MASK;
    end else if (sub == OFS_LINEAR_REG_PAIR_CONTROL) begin
      m = LIN_PAIR_MASK;
    end else if (sub == OFS_LINEAR_REG_FOUR_CONTROL) begin
      m = DDR_VARIANT ? LIN_FOUR_MASK_DDR : LIN_FOUR_MASK_BASE;
    end else if (sub == OFS_POWERDOWN_ORDER_FIRST) begin
      m = PD_MASK;
    end
    return m;
  endfunction

  // Edges come from the second sync stage only
  assign scl_rise = st_reg.sync2.scl && !st_reg.scl_prev;
  assign scl_fall = !st_reg.sync2.scl && st_reg.scl_prev;
  assign start_det = st_reg.sync2.scl && st_reg.scl_prev &&
                     !st_reg.sync2.sda && st_reg.sda_prev;
  assign stop_det = st_reg.sync2.scl && st_reg.scl_prev &&
                    st_reg.sync2.sda && !st_reg.sda_prev;
  assign ptr_hit = (st_reg.ptr >= SUB_FIRST) && (st_reg.ptr <= SUB_LAST);
  assign ptr_idx = 5'(st_reg.ptr - SUB_FIRST);
  // Unmapped pointer reads as zero
  assign rd_byte = ptr_hit ? st_reg.staged[ptr_idx] : CMD_RESET;

  always_comb begin
    st_next = st_reg;
    st_next.sync1 = {scl_in, sda_in, linear_four_enable_pin,
                     linear_three_enable_pin, linear_two_enable_pin,
                     switcher_four_enable_pin, switcher_three_enable_pin,
                     switcher_two_enable_pin, switcher_one_enable_pin};
    st_next.sync2 = st_reg.sync1;
    st_next.scl_prev = st_reg.sync2.scl;
    st_next.sda_prev = st_reg.sync2.sda;
    st_next.sda_out = 1'b0;

    if (stop_det) begin
      // Apply everything staged since the last STOP, across repeated STARTs
      if (st_reg.pending) begin
        st_next.applied = st_reg.staged;
      end
      st_next.pending = 1'b0;
      st_next.phase = ST_IDLE;
      st_next.sda_oe = 1'b0;
    end else if (start_det) begin
      // Staged values and pointer survive a repeated START
      st_next.phase = ST_ADDR;
      st_next.bit_cnt = 4'h0;
      st_next.sda_oe = 1'b0;
    end else begin
      case (st_reg.phase)
        ST_ADDR, ST_WR_BYTE: begin
          if (scl_rise) begin
            st_next.shift = {st_reg.shift[6:0], st_reg.sync2.sda};
            st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
          end else if (scl_fall && st_reg.bit_cnt == BITS_PER_BYTE) begin
            st_next.bit_cnt = 4'h0;
            if (st_reg.phase == ST_ADDR) begin
              if (st_reg.shift == ADDR_WR) begin
                st_next.rd_mode = 1'b0;
                st_next.expect_sub = 1'b1;
                st_next.sda_oe = 1'b1;
                st_next.phase = ST_ACK;
              end else if (st_reg.shift == ADDR_RD) begin
                st_next.rd_mode = 1'b1;
                st_next.sda_oe = 1'b1;
                st_next.phase = ST_ACK;
              end else begin
                st_next.phase = ST_IDLE;
              end
            end else begin
              if (st_reg.expect_sub) begin
                // Pointer also serves later bare reads
                st_next.ptr = st_reg.shift;
              end else if (ptr_hit) begin
                st_next.staged[ptr_idx] =
                  st_reg.shift & wr_mask(st_reg.ptr);
                st_next.pending = 1'b1;
              end
              st_next.expect_sub = !st_reg.expect_sub;
              st_next.sda_oe = 1'b1;
              st_next.phase = ST_ACK;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (st_reg.rd_mode) begin
              // First data bit goes out as the ack clock ends
              st_next.shift = rd_byte;
              st_next.sda_oe = !rd_byte[7];
              st_next.bit_cnt = 4'h1;
              st_next.phase = ST_RD_BYTE;
            end else begin
              st_next.sda_oe = 1'b0;
              st_next.phase = ST_WR_BYTE;
            end
          end
        end
        ST_RD_BYTE: begin
          if (scl_fall) begin
            if (st_reg.bit_cnt == BITS_PER_BYTE) begin
              st_next.sda_oe = 1'b0;
              st_next.phase = ST_RD_ACK;
            end else begin
              st_next.sda_oe = !st_reg.shift[6];
              st_next.shift = {st_reg.shift[6:0], 1'b0};
              st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
            end
          end
        end
        ST_RD_ACK: begin
          // Master ack or nack alike: wait quietly for START or STOP
          if (scl_rise) begin
            st_next.phase = ST_IDLE;
          end
        end
        default: begin
          st_next.phase = ST_IDLE;
        end
      endcase
    end

    // Register bit set forces the rail on, clear bit defers to the pin except for LDO4 on the DDR variant
    for (int i = 0; i < 4; i++) begin
      st_next.rail_en[i] = st_reg.applied[i][SW_EN_BIT] ||
                           st_reg.sync2.en_pin[i];
    end
    st_next.rail_en[4] =
      st_reg.applied[OFS_LINEAR_REG_PAIR_CONTROL - SUB_FIRST][LIN2_EN_BIT] ||
      st_reg.sync2.en_pin[4];
    st_next.rail_en[5] =
      st_reg.applied[OFS_LINEAR_REG_PAIR_CONTROL - SUB_FIRST][LIN3_EN_BIT] ||
      st_reg.sync2.en_pin[5];
    // The DDR variant enables LDO4 from the register only
    st_next.rail_en[6] =
      st_reg.applied[OFS_LINEAR_REG_FOUR_CONTROL - SUB_FIRST][LIN4_EN_BIT] ||
      (!DDR_VARIANT && st_reg.sync2.en_pin[6]);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
      // Idle levels, so leaving reset shows no false SCL or SDA edge
      st_reg.sync1.scl <= BUS_IDLE;
      st_reg.sync1.sda <= BUS_IDLE;
      st_reg.sync2.scl <= BUS_IDLE;
      st_reg.sync2.sda <= BUS_IDLE;
      st_reg.scl_prev <= BUS_IDLE;
      st_reg.sda_prev <= BUS_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sda_out = st_reg.sda_out;
  assign sda_oe = st_reg.sda_oe;
  assign cmd_applied = st_reg.applied;
  assign rail_enable = st_reg.rail_en;

  // Checks

  sequence addr_byte_done;
    st_reg.phase == ST_ADDR && scl_fall && st_reg.bit_cnt == BITS_PER_BYTE &&
    !start_det && !stop_det;
  endsequence

  sequence data_byte_done;
    st_reg.phase == ST_WR_BYTE && scl_fall &&
    st_reg.bit_cnt == BITS_PER_BYTE && !start_det && !stop_det;
  endsequence

  sequence store_byte_done;
    data_byte_done ##0 (!st_reg.expect_sub && ptr_hit);
  endsequence

  data_ack_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    data_byte_done |=> st_reg.sda_oe && st_reg.phase == ST_ACK)
    else $error("write byte not acknowledged");

  store_pending_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    store_byte_done |=> st_reg.pending && st_reg.expect_sub)
    else $error("stored byte not marked pending");

  sw_store_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    store_byte_done ##0 st_reg.ptr == OFS_SWITCHER_ONE_CONTROL
      |=> st_reg.staged[0] == $past(st_reg.shift))
    else $error("data byte not stored at its sub-address");

  lin_four_zero_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    st_reg.staged[OFS_LINEAR_REG_FOUR_CONTROL - SUB_FIRST][7:5] == 3'b000 &&
      (DDR_VARIANT ||
       st_reg.staged[OFS_LINEAR_REG_FOUR_CONTROL - SUB_FIRST][4:3] == 2'b00))
    else $error("reserved bits of linear four register not zero");

  sw_rail_on_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    st_reg.applied[0][SW_EN_BIT] |=> st_reg.rail_en[0])
    else $error("switcher enable bit did not force rail on");

  ldo4_reg_only_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    DDR_VARIANT &&
      !st_reg.applied[OFS_LINEAR_REG_FOUR_CONTROL - SUB_FIRST][LIN4_EN_BIT]
      |=> !st_reg.rail_en[6])
    else $error("linear four enabled without its register bit");

  rd_nack_quiet_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    st_reg.phase == ST_RD_ACK |=> !st_reg.sda_oe &&
      $stable(st_reg.ptr) && $stable(st_reg.staged))
    else $error("master ack slot disturbed the port");

  rd_ptr_hold_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    st_reg.phase == ST_RD_BYTE |=> $stable(st_reg.ptr))
    else $error("read pointer moved during a read");

  applied_only_stop_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    !stop_det |=> $stable(st_reg.applied))
    else $error("applied registers changed without STOP");

  stop_applies_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    stop_det && st_reg.pending |=> st_reg.applied == $past(st_reg.staged)
      && !st_reg.pending)
    else $error("STOP did not apply staged registers");

  restart_keeps_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    start_det |=> $stable(st_reg.staged) && $stable(st_reg.ptr)
      && st_reg.phase == ST_ADDR)
    else $error("repeated START disturbed staged data");

  own_addr_ack_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    addr_byte_done ##0 (st_reg.shift == ADDR_WR || st_reg.shift == ADDR_RD)
      |=> st_reg.sda_oe && st_reg.phase == ST_ACK)
    else $error("own address not acknowledged");

  foreign_addr_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    addr_byte_done ##0 (st_reg.shift != ADDR_WR && st_reg.shift != ADDR_RD)
      |=> !st_reg.sda_oe && st_reg.phase == ST_IDLE)
    else $error("foreign address acknowledged");

  dir_bit_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    addr_byte_done ##0 st_reg.shift == ADDR_RD |=> st_reg.rd_mode)
    else $error("read address not decoded as read");

  subaddr_ptr_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    data_byte_done ##0 st_reg.expect_sub
      |=> st_reg.ptr == $past(st_reg.shift) && !st_reg.expect_sub)
    else $error("sub-address not captured as pointer");

  reserved_zero_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    st_reg.staged[OFS_LINEAR_REG_PAIR_CONTROL - SUB_FIRST][7:6] == 2'b00)
    else $error("reserved bits of pair register not zero");

  read_first_bit_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    st_reg.phase == ST_ACK && st_reg.rd_mode && scl_fall && !stop_det &&
    !start_det |=> st_reg.phase == ST_RD_BYTE &&
      st_reg.sda_oe == !$past(rd_byte[7]))
    else $error("first read bit not driven after ack");

  read_release_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    st_reg.phase == ST_RD_BYTE && scl_fall &&
    st_reg.bit_cnt == BITS_PER_BYTE && !start_det && !stop_det
      |=> !st_reg.sda_oe && st_reg.phase == ST_RD_ACK)
    else $error("data line not released for master ack");

endmodule

`default_nettype wire

/* File: pmc_i2c_master.sv */
`timescale 1ns/1ns
`default_nettype none

module pmc_i2c_master (
  // Clock
  input wire logic clk_sys,
  // Bus wire level and master drive
  input wire logic sda,
  output logic scl,
  output logic sda_m
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  // Eight system clocks per quarter bit, sixteen per SCL phase, keeps the slave's sync margin
  task automatic hp;
    repeat (8) @(posedge clk_sys);
  endtask

  // Data moves only in the middle of the low phase, never at the fall
  task automatic clk_bit(input logic b, output logic r);
    hp();
    sda_m <= b;
    hp();
    scl <= 1'b1;
    hp();
    r = sda;
    hp();
    scl <= 1'b0;
  endtask

  task automatic start;
    sda_m <= 1'b1;
    hp();
    scl <= 1'b1;
    hp();
    sda_m <= 1'b0;
    hp();
    scl <= 1'b0;
  endtask

  task automatic stop;
    hp();
    sda_m <= 1'b0;
    hp();
    scl <= 1'b1;
    hp();
    sda_m <= 1'b1;
    hp();
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], r);
    end
    clk_bit(1'b1, r);
    ack = ~r;
  endtask

  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, d[i]);
    end
    clk_bit(~mack, r);
  endtask
endmodule

`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ns
`default_nettype none

module tb
  import pmc_pkg::*;
;
  logic clk_sys;
  logic resetn;
  logic scl;
  logic sda_m;
  logic sda_w;
  logic sda_out;
  logic sda_oe;
  logic [6:0] pin;
  logic [NUM_CMD-1:0][7:0] applied;
  logic [6:0] rail;
  logic scl_d;
  logic sda_md;
  logic sda_wd;
  logic sda_out_d;
  logic sda_oe_d;
  logic [NUM_CMD-1:0][7:0] applied_ddr;
  logic [6:0] rail_ddr;
  logic [7:0] rd_val;
  int errors;
  int samples_checked;

  // Pull-up: low when either side pulls down
  assign sda_w = sda_m & (sda_oe ? sda_out : 1'b1);
  assign sda_wd = sda_md & (sda_oe_d ? sda_out_d : 1'b1);

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  pmc_i2c_command_port #(.DDR_VARIANT(1'b0)) u_dut (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .scl_in(scl),
    .sda_in(sda_w),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .switcher_one_enable_pin(pin[0]),
    .switcher_two_enable_pin(pin[1]),
    .switcher_three_enable_pin(pin[2]),
    .switcher_four_enable_pin(pin[3]),
    .linear_two_enable_pin(pin[4]),
    .linear_three_enable_pin(pin[5]),
    .linear_four_enable_pin(pin[6]),
    .cmd_applied(applied),
    .rail_enable(rail)
  );

  pmc_i2c_master u_mst (
    .clk_sys(clk_sys),
    .sda(sda_w),
    .scl(scl),
    .sda_m(sda_m)
  );

  // Second variant on a bus of its own
  pmc_i2c_command_port #(.DDR_VARIANT(1'b1)) u_dut_ddr (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .scl_in(scl_d),
    .sda_in(sda_wd),
    .sda_out(sda_out_d),
    .sda_oe(sda_oe_d),
    .switcher_one_enable_pin(pin[0]),
    .switcher_two_enable_pin(pin[1]),
    .switcher_three_enable_pin(pin[2]),
    .switcher_four_enable_pin(pin[3]),
    .linear_two_enable_pin(pin[4]),
    .linear_three_enable_pin(pin[5]),
    .linear_four_enable_pin(pin[6]),
    .cmd_applied(applied_ddr),
    .rail_enable(rail_ddr)
  );

  pmc_i2c_master u_mst_ddr (
    .clk_sys(clk_sys),
    .sda(sda_wd),
    .scl(scl_d),
    .sda_m(sda_md)
  );

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask

  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic ack;
    u_mst.wr_byte(b, ack);
    chk("ack", {7'h00, exp_ack}, {7'h00, ack});
  endtask

  task automatic send_ddr(input logic [7:0] b, input logic exp_ack);
    logic ack;
    u_mst_ddr.wr_byte(b, ack);
    chk("ddr ack", {7'h00, exp_ack}, {7'h00, ack});
  endtask

  task automatic set_ptr(input logic [7:0] sub);
    u_mst.start();
    send(ADDR_WR_BASE, 1'b1);
    send(sub, 1'b1);
  endtask

  task automatic rd_now(input logic [7:0] exp, input logic mack);
    logic [7:0] d;
    u_mst.start();
    send(ADDR_RD_BASE, 1'b1);
    u_mst.rd_byte(mack, d);
    chk("read data", exp, d);
  endtask

  task automatic rreg(input logic [7:0] sub, input logic [7:0] exp);
    set_ptr(sub);
    rd_now(exp, 1'b0);
    u_mst.stop();
  endtask

  // Two sync stages, detect, register, then the rail stage
  task automatic settle;
    repeat (6) @(posedge clk_sys);
  endtask

  initial begin
    repeat (100000) @(posedge clk_sys);
    errors++;
    final_report();
  end

  initial begin
    resetn = 1'b0;
    pin = 7'h00;
    errors = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < 7; i++) begin
      chk("reset value", 8'h00, applied[i]);
      rreg(8'(i + 1), 8'h00);
    end
    chk("rails", 8'h00, {1'b0, rail});
    $display("test reset done");

    set_ptr(OFS_SWITCHER_ONE_CONTROL);
    send(8'h80, 1'b1);
    send(OFS_LINEAR_REG_PAIR_CONTROL, 1'b1);
    send(8'hff, 1'b1);
    send(OFS_POWERDOWN_ORDER_FIRST, 1'b1);
    send(8'he4, 1'b1);
    send(8'h17, 1'b1);
    send(8'haa, 1'b1);
    settle();
    chk("before stop", 8'h00, applied[0]);
    u_mst.stop();
    settle();
    chk("switcher one", 8'h80, applied[0]);
    chk("linear pair", 8'h3f, applied[4]);
    chk("powerdown", 8'he4, applied[6]);
    chk("rails", 8'h31, {1'b0, rail});
    rreg(8'h17, 8'h00);
    rreg(OFS_LINEAR_REG_PAIR_CONTROL, 8'h3f);
    $display("test multi write done");

    set_ptr(OFS_SWITCHER_TWO_CONTROL);
    send(8'h55, 1'b1);
    u_mst.start();
    send(8'h50, 1'b0);
    settle();
    chk("held", 8'h00, applied[1]);
    u_mst.stop();
    settle();
    chk("after stop", 8'h55, applied[1]);
    rd_now(8'h55, 1'b1);
    u_mst.stop();
    $display("test repeated start done");

    set_ptr(OFS_LINEAR_REG_FOUR_CONTROL);
    send(8'hff, 1'b1);
    u_mst.stop();
    settle();
    chk("linear four", 8'h07, applied[5]);
    chk("rails", 8'h71, {1'b0, rail});
    rd_now(8'h07, 1'b0);
    rd_now(8'h07, 1'b1);
    u_mst.stop();
    $display("test pointer done");

    u_mst.start();
    send(ADDR_WR_DDR, 1'b0);
    u_mst.stop();
    u_mst.start();
    send(ADDR_RD_DDR, 1'b0);
    u_mst.stop();
    $display("test address done");

    set_ptr(OFS_SWITCHER_ONE_CONTROL);
    send(8'h7f, 1'b1);
    u_mst.stop();
    chk("switcher fields", 8'h7f, applied[0]);
    pin <= 7'h03;
    settle();
    chk("pins high", 8'h73, {1'b0, rail});
    rreg(OFS_SWITCHER_ONE_CONTROL, 8'h7f);
    pin <= 7'h00;
    settle();
    chk("pins low", 8'h70, {1'b0, rail});
    $display("test enable pins done");

    pin <= 7'h40;
    settle();
    chk("ddr pin ignored", 8'h00, {1'b0, rail_ddr});
    u_mst_ddr.start();
    send_ddr(ADDR_WR_BASE, 1'b0);
    u_mst_ddr.start();
    send_ddr(ADDR_WR_DDR, 1'b1);
    send_ddr(OFS_LINEAR_REG_FOUR_CONTROL, 1'b1);
    send_ddr(8'hff, 1'b1);
    u_mst_ddr.stop();
    settle();
    chk("ddr linear four", 8'h1f, applied_ddr[5]);
    chk("ddr rails", 8'h40, {1'b0, rail_ddr});
    u_mst_ddr.start();
    send_ddr(ADDR_RD_DDR, 1'b1);
    u_mst_ddr.rd_byte(1'b0, rd_val);
    chk("ddr read", 8'h1f, rd_val);
    u_mst_ddr.stop();
    pin <= 7'h00;
    $display("test ddr variant done");

    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("reset again", 8'h00, applied[4]);
    chk("reset rails", 8'h00, {1'b0, rail});
    chk("ddr reset", 8'h00, applied_ddr[5]);
    rreg(OFS_SWITCHER_ONE_CONTROL, 8'h00);
    $display("test mid-run reset done");
    final_report();
  end
endmodule

`default_nettype wire
